// ---- psr_shift_reg.sv ----
// eight-stage parallel/serial-in, serial-out shift register
`timescale 1ns/1ps
// Functional notes
// - eight stages form a chain and the last one feeds the serial output.
// - with select high an active edge shifts serial_in into stage one.
// - with select low an active edge loads inputs a..h into stages 1..8.
// - on a parallel load the serial input is ignored.
// - apart from clear, stages change only on a rising edge of NOR(clock, clock gate) or when a parked edge fires.
// - either clock input held high freezes all stages, except that an already parked edge still fires.
// - active-low clear forces every stage and the output to zero on the next core_clk_i edge.
module psr_shift_reg
  import psr_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  // register controls, sampled on core_clk_i
  input  wire logic       async_clear_n_i,
  input  wire logic       shift_load_select_i,
  input  wire logic       shift_clk_i,
  input  wire logic       clock_gate_input_i,
  // data inputs, bit 7 is input a (first stage), bit 0 is input h
  input  wire logic       serial_in_i,
  input  wire logic [7:0] par_data_i,
  // stage view and serial output
  output logic [7:0]      stages_o,
  output logic            serial_out_o,
  // buffered stream of output bits, one per active edge
  output logic            bit_valid_o,
  output logic            bit_data_o,
  input  wire logic       bit_ready_i,
  output logic            stall_o
);
  logic [7:0] stage_reg;
  logic [7:0] stage_next;
  logic       nor_prev_reg;
  logic       nor_now;
  logic       nor_rise;
  logic       active_edge;
  logic       pend_reg;
  logic       pend_load;
  logic       pend_sel_reg;
  logic       pend_ser_reg;
  logic [7:0] pend_par_reg;
  logic       eff_sel;
  logic       eff_ser;
  logic [7:0] eff_par;
  logic       buf_ready;
  logic       buf_valid;
  logic       buf_data;
  logic       buf_take;
  logic       out_reg;
  logic       valid_reg;
  logic       data_reg;
  logic       stall_reg;

  // combined clock path; either input high holds it low
  assign nor_now     = ~(shift_clk_i | clock_gate_input_i);
  assign nor_rise    = nor_now && !nor_prev_reg;
  // a full buffer with no edge parked defers the edge instead of losing its bit
  assign active_edge = (nor_rise || pend_reg) && buf_ready;
  // park a refused rise; a rise that meets a full buffer with one already
  // parked is dropped, so the controller must not pulse faster than drain
  assign pend_load   = nor_rise && (pend_reg ? buf_ready : !buf_ready);
  // controls of a parked edge replace the live pins when it fires
  assign eff_sel     = pend_reg ? pend_sel_reg : shift_load_select_i;
  assign eff_ser     = pend_reg ? pend_ser_reg : serial_in_i;
  assign eff_par     = pend_reg ? pend_par_reg : par_data_i;

  // next stage value: load a..h, else shift serial_in into stage one
  always_comb begin
    if (!eff_sel) begin
      stage_next = eff_par;
    end else begin
      stage_next = {eff_ser, stage_reg[PSR_STAGES-1:1]};
    end
  end

  // edge history of the combined clock
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nor_prev_reg <= PSR_BIT_RESET;
    end else begin
      nor_prev_reg <= nor_now; // refused rises are parked, not held here
    end
  end

  // parked edge flag; clear drops a parked edge as it drops everything
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_reg <= PSR_BIT_RESET;
    end else if (!async_clear_n_i) begin
      pend_reg <= PSR_BIT_RESET;
    end else if (pend_load) begin
      pend_reg <= 1'h1;
    end else if (pend_reg && buf_ready) begin
      pend_reg <= PSR_BIT_RESET;
    end
  end

  // controls captured together with a parked edge
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_sel_reg <= PSR_BIT_RESET;
      pend_ser_reg <= PSR_BIT_RESET;
      pend_par_reg <= PSR_STAGE_RESET;
    end else if (pend_load) begin
      pend_sel_reg <= shift_load_select_i;
      pend_ser_reg <= serial_in_i;
      pend_par_reg <= par_data_i;
    end
  end

  // stage chain; clear overrides every other input
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage_reg <= PSR_STAGE_RESET;
      out_reg   <= PSR_BIT_RESET;
    end else if (!async_clear_n_i) begin
      stage_reg <= PSR_STAGE_RESET;
      out_reg   <= PSR_BIT_RESET;
    end else if (active_edge) begin
      stage_reg <= stage_next;
      out_reg   <= stage_next[0];
    end
  end

  // the clear acts on the next clock: inputs are synchronous here
  psr_skid_buf u_buf (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .clear_i     (!async_clear_n_i),
    .in_valid_i  (active_edge && async_clear_n_i),
    .in_data_i   (stage_next[0]),
    .in_ready_o  (buf_ready),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (buf_take)
  );

  // registered stream outputs and stall flag
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_reg <= PSR_BIT_RESET;
      data_reg  <= PSR_BIT_RESET;
      stall_reg <= PSR_BIT_RESET;
    end else begin
      if (buf_take || !async_clear_n_i) begin
        valid_reg <= buf_valid && async_clear_n_i;
        data_reg  <= buf_data;
      end
      stall_reg <= !buf_ready;
    end
  end

  assign stages_o     = stage_reg;
  assign serial_out_o = out_reg;
  assign bit_valid_o  = valid_reg;
  assign bit_data_o   = data_reg;
  assign stall_o      = stall_reg;

  // the buffer gives up a bit exactly when the output register takes one
  assign buf_take = !valid_reg || bit_ready_i;

  sequence s_clear;
    !async_clear_n_i;
  endsequence

  AST_CLEAR_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    s_clear |=> (stage_reg == PSR_STAGE_RESET) && !serial_out_o)
    else $error("clear did not zero the stages");

  AST_LOAD: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    active_edge && async_clear_n_i && !eff_sel
      |=> stage_reg == $past(eff_par))
    else $error("parallel load mismatch");

  AST_SHIFT: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    active_edge && async_clear_n_i && eff_sel
      |=> stage_reg[7] == $past(eff_ser)
          && stage_reg[6:0] == $past(stage_reg[7:1]))
    else $error("shift mismatch");

  AST_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    async_clear_n_i && !pend_reg && (shift_clk_i || clock_gate_input_i)
      |=> $stable(stage_reg))
    else $error("stages moved while clock path held");

  AST_EDGE_ONLY: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    async_clear_n_i && !active_edge |=> $stable(stage_reg))
    else $error("stages moved without an edge");

  AST_OUT_LAST: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    serial_out_o == stage_reg[0])
    else $error("output is not the last stage");

  AST_SER_IGNORED: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    active_edge && async_clear_n_i && !eff_sel
      |=> stage_reg[7] == $past(eff_par[7]))
    else $error("serial bit leaked into a load");

  // a rise refused by a full buffer with no edge parked is parked, not lost
  sequence s_rise_refused;
    nor_rise && !buf_ready && !pend_reg && async_clear_n_i;
  endsequence

  AST_PARK: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    s_rise_refused |=> pend_reg && $stable(stage_reg))
    else $error("refused edge was not parked");

  AST_STREAM_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    bit_valid_o && !bit_ready_i && async_clear_n_i
      |=> bit_valid_o && $stable(bit_data_o))
    else $error("stream bit dropped while stalled");

  AST_CLEAR_STREAM: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    s_clear |=> !bit_valid_o && !pend_reg)
    else $error("clear left stream state behind");
endmodule

// ---- psr_pkg.sv ----
// package of constants for the parallel/serial shift register block
package psr_pkg;
  localparam int          PSR_STAGES      = 8;
  localparam int          PSR_LAST        = PSR_STAGES - 1;
  localparam logic [7:0]  PSR_STAGE_RESET = 8'h00;
  localparam logic        PSR_BIT_RESET   = 1'h0;
  localparam int          PSR_BUF_DEPTH   = 2;
  localparam logic [1:0]  PSR_CNT_ZERO    = 2'h0;
  localparam logic [1:0]  PSR_CNT_ONE     = 2'h1;
  localparam logic [1:0]  PSR_CNT_TWO     = 2'h2;
endpackage

// ---- psr_skid_buf.sv ----
// two-entry valid/ready buffer for the serial output bit
`timescale 1ns/1ps
module psr_skid_buf
  import psr_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic clear_i,
  // filling side
  input  wire logic in_valid_i,
  input  wire logic in_data_i,
  output logic      in_ready_o,
  // draining side
  output logic      out_valid_o,
  output logic      out_data_o,
  input  wire logic out_ready_i
);
  logic [1:0] mem_reg;
  logic [1:0] cnt_reg;
  logic       rd_ptr_reg;
  logic       wr_ptr_reg;
  logic       push;
  logic       pop;

  // handshake terms; full refuses new bits so nothing is overwritten
  assign in_ready_o  = (cnt_reg != PSR_CNT_TWO);
  assign out_valid_o = (cnt_reg != PSR_CNT_ZERO);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage and pointers; clear empties the buffer like reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_reg    <= PSR_CNT_ZERO;
      cnt_reg    <= PSR_CNT_ZERO;
      rd_ptr_reg <= PSR_BIT_RESET;
      wr_ptr_reg <= PSR_BIT_RESET;
    end else if (clear_i) begin
      mem_reg    <= PSR_CNT_ZERO;
      cnt_reg    <= PSR_CNT_ZERO;
      rd_ptr_reg <= PSR_BIT_RESET;
      wr_ptr_reg <= PSR_BIT_RESET;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data_i;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + PSR_CNT_ONE;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - PSR_CNT_ONE;
      end
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i) cnt_reg <= PSR_CNT_TWO)
    else $error("buffer count above two");
endmodule

// ---- psr_ctrl_model.sv ----
// model of the controlling logic that clocks the shift register
`timescale 1ns/1ps
module psr_ctrl_model (
  // system clock
  input  wire logic core_clk_i,
  // register clock pair
  output logic      shift_clk_o,
  output logic      gate_o
);
  // clock rests high so the gate may change between pulses
  initial begin
    shift_clk_o = 1'h1;
    gate_o      = 1'h0;
  end
  // with the gate low, one low pulse gives one rising edge of the nor path, one cycle long
  task automatic pulse();
    @(negedge core_clk_i) shift_clk_o = 1'h0;
    @(negedge core_clk_i) shift_clk_o = 1'h1;
  endtask
  // only called between pulses, while the clock is high
  task automatic set_gate(input logic v);
    @(negedge core_clk_i) gate_o = v;
  endtask
endmodule

// ---- tb_psr_shift_reg.sv ----
// self-checking bench for the shift register and its output stream
`timescale 1ns/1ps
module tb_psr_shift_reg;
  import psr_pkg::*;
  logic       core_clk_i, resetn_i, clr_n, sel, serial_in, rdy;
  logic       sclk, gate, sout, bvalid, bdata, stall;
  logic [7:0] par, stages, exp_st, held;
  int         mismatches, n_tests;
  logic       q[$];
  psr_ctrl_model psr_ctrl_model_inst (.core_clk_i(core_clk_i),
    .shift_clk_o(sclk), .gate_o(gate));
  psr_shift_reg psr_shift_reg_inst (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .async_clear_n_i(clr_n),
    .shift_load_select_i(sel), .shift_clk_i(sclk),
    .clock_gate_input_i(gate), .serial_in_i(serial_in), .par_data_i(par),
    .stages_o(stages), .serial_out_o(sout), .bit_valid_o(bvalid),
    .bit_data_o(bdata), .bit_ready_i(rdy), .stall_o(stall));
  always #5 core_clk_i = ~core_clk_i;
  task automatic check(input logic [7:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // first stage is bit 7, shifting runs toward bit 0
  function automatic logic [7:0] nxt(input logic [7:0] s, input logic sh,
                                     input logic si, input logic [7:0] p);
    return sh ? {si, s[7:1]} : p;
  endfunction
  // one active edge with fresh random data on every data input
  task automatic step(input logic sh);
    @(negedge core_clk_i);
    sel = sh;
    serial_in = 1'($urandom);
    par = 8'($urandom);
    exp_st = nxt(exp_st, sh, serial_in, par);
    q.push_back(exp_st[0]);
    psr_ctrl_model_inst.pulse();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      step(i % 9 != 0);
      check(stages, exp_st, "stages");
      check(sout, exp_st[0], "serial out");
    end
  endtask
  // every accepted stream bit must match the bit expected in order
  always @(posedge core_clk_i) begin
    if (resetn_i && bvalid === 1'h1 && rdy === 1'h1) begin
      check(bdata, q.size() ? q.pop_front() : 1'hx, "stream");
    end
  end
  // hang guard
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    int k;
    core_clk_i = 1'h0; resetn_i = 1'h0; clr_n = 1'h1; sel = 1'h1;
    serial_in = 1'h0; par = 8'h00; rdy = 1'h1; exp_st = PSR_STAGE_RESET;
    mismatches = 0; n_tests = 0;
    void'($urandom(72004));
    repeat (10) @(negedge core_clk_i);
    resetn_i = 1'h1;
    run(30);
    // inhibited pulses must leave every stage alone
    psr_ctrl_model_inst.set_gate(1'h1);
    repeat (3) begin
      @(negedge core_clk_i) sel = 1'h0;
      par = ~exp_st;
      psr_ctrl_model_inst.pulse();
    end
    repeat (2) @(posedge core_clk_i);
    #1 check(stages, exp_st, "inhibit");
    psr_ctrl_model_inst.set_gate(1'h0);
    // consumer stalls: fill the buffer, then drain with no bit lost
    @(negedge core_clk_i) rdy = 1'h0;
    for (k = 0; k < 6 && stall !== 1'h1; k++) step(1'h1);
    check(stall, 1'h1, "stall");
    // an edge met by a full buffer is parked, then lands once there is room
    held = exp_st;
    step(1'h1);
    check(stages, held, "parked");
    @(negedge core_clk_i) rdy = 1'h1;
    repeat (8) @(posedge core_clk_i);
    #1 check(stages, exp_st, "after drain");
    check(q.size(), 0, "bits left");
    // clear after the drain zeroes stages, serial out and stream valid
    @(negedge core_clk_i) clr_n = 1'h0;
    sel = 1'h0;
    par = 8'hFF;
    repeat (2) @(posedge core_clk_i);
    #1 check(stages, PSR_STAGE_RESET, "clear");
    check({sout, bvalid}, 2'h0, "clear out");
    @(negedge core_clk_i) clr_n = 1'h1;
    q.delete();
    exp_st = PSR_STAGE_RESET;
    run(20);
    give_verdict();
  end
endmodule
